// >>> logic/lbsi_pkg.sv
package lbsi_pkg;
  // ----------------------------------------
  // Bus geometry
  // ----------------------------------------
  localparam int LAD_W = 32;
  localparam int SIZE_W = 2;
  localparam int ADDR_LSB = 2;
  localparam int WADDR_W = 30;
  localparam int BE_W = 4;
  localparam int BYTE_W = 8;
  localparam int BURST_MAX = 4;
  localparam int HALF_W = 16;
  localparam int HBE_W = 2;
  // ----------------------------------------
  // Decode and buffering
  // ----------------------------------------
  localparam int CS_W = 4;
  localparam int CS_SEL_LSB = 28;
  localparam int CS_SEL_W = 2;
  localparam logic [1:0] IO_REGION = 2'h3;
  localparam logic [1:0] SIZE_ONE = 2'h0;
  localparam int FIFO_DEPTH = 32;
  // Buffered write word: {cs, word address, lanes, data}
  localparam int PAY_DATA_LSB = 0;
  localparam int PAY_BE_LSB = PAY_DATA_LSB + LAD_W;
  localparam int PAY_ADDR_LSB = PAY_BE_LSB + BE_W;
  localparam int PAY_CS_LSB = PAY_ADDR_LSB + WADDR_W;
  localparam int PAY_W = PAY_CS_LSB + CS_W;
  // ----------------------------------------
  // States
  // ----------------------------------------
  typedef enum logic [2:0] {MST_IDLE, MST_ADDR, MST_DATA, MST_RECOV, MST_HOLD} lbsi_mst_state_type;
  typedef enum logic [0:0] {SLV_IDLE, SLV_DATA} lbsi_slv_state_type;
endpackage : lbsi_pkg

// >>> logic/lbsi_bus_if.sv
`timescale 1ns/1ps
interface lbsi_bus_if;
  logic [lbsi_pkg::LAD_W-1:0] m_lad;
  logic m_lad_oe;
  logic [lbsi_pkg::LAD_W-1:0] s_lad;
  logic s_lad_oe;
  logic [lbsi_pkg::LAD_W-1:0] lad;
  logic ale_n;
  logic address_status_strobe_n;
  logic w_r;
  logic data_direction;
  logic data_transceiver_enable_n;
  logic [lbsi_pkg::BE_W-1:0] be;
  logic ready_n;
  logic bus_grant;
  // ----------------------------------------
  // Shared address/data wire
  // ----------------------------------------
  // Undriven wire reads as zero; no floating value inside the design
  assign lad = m_lad_oe ? m_lad : (s_lad_oe ? s_lad : '0);
  modport proc (
    output m_lad, m_lad_oe, ale_n, address_status_strobe_n, w_r, data_direction,
    output data_transceiver_enable_n, be, bus_grant,
    input lad, ready_n
  );
  modport slave (
    output s_lad, s_lad_oe, ready_n,
    input lad, ale_n, address_status_strobe_n, w_r, data_direction,
    input data_transceiver_enable_n, be, bus_grant
  );
endinterface : lbsi_bus_if

// >>> logic/lbsi_proc_end.sv
`timescale 1ns/1ps
module lbsi_proc_end (
  input wire logic CLOCK_I, // System clock
  input wire logic SYS_RST_I, // Async reset, active high
  lbsi_bus_if.proc BUS, // Local bus pins
  input wire logic REQ_VALID_I, // Transaction request
  output logic REQ_READY_O, // Request may be taken
  input wire logic REQ_WRITE_I, // 1 write, 0 read
  input wire logic [lbsi_pkg::WADDR_W-1:0] REQ_ADDR_I, // First word address
  input wire logic [lbsi_pkg::SIZE_W-1:0] REQ_SIZE_I, // Words minus one
  input wire logic [lbsi_pkg::BE_W-1:0] REQ_BE_I, // Byte lanes, active high
  input wire logic [lbsi_pkg::BURST_MAX*lbsi_pkg::LAD_W-1:0] REQ_WDATA_I, // Write words, first lowest
  input wire logic HOLD_I, // External master asks for bus
  output logic BUS_GRANT_O, // Bus handed to external master
  output logic [lbsi_pkg::LAD_W-1:0] RD_DATA_O, // Read word
  output logic RD_VALID_O, // Read word strobe
  output logic DONE_O // Last word finished
);
  localparam int WD_W = lbsi_pkg::BURST_MAX * lbsi_pkg::LAD_W;
  lbsi_pkg::lbsi_mst_state_type state_reg;
  logic hold_meta_reg;
  logic hold_sync_reg;
  logic write_reg;
  logic [lbsi_pkg::SIZE_W-1:0] size_reg;
  logic [lbsi_pkg::SIZE_W-1:0] word_reg;
  logic [WD_W-1:0] wdata_reg;
  logic [lbsi_pkg::LAD_W-1:0] lad_reg;
  logic lad_oe_reg;
  logic ale_n_reg;
  logic ads_n_reg;
  logic den_n_reg;
  logic [lbsi_pkg::BE_W-1:0] be_reg;
  logic take;

  assign take = (state_reg == lbsi_pkg::MST_IDLE) && REQ_VALID_I && REQ_READY_O && !hold_sync_reg;
  assign BUS.m_lad = lad_reg;
  assign BUS.m_lad_oe = lad_oe_reg;
  assign BUS.ale_n = ale_n_reg;
  assign BUS.address_status_strobe_n = ads_n_reg;
  assign BUS.w_r = write_reg;
  assign BUS.data_direction = write_reg;
  assign BUS.data_transceiver_enable_n = den_n_reg;
  assign BUS.be = be_reg;
  assign BUS.bus_grant = BUS_GRANT_O;

  // ----------------------------------------
  // Hold request synchroniser
  // ----------------------------------------
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      hold_meta_reg <= 1'b0;
      hold_sync_reg <= 1'b0;
    end
    else
    begin
      hold_meta_reg <= HOLD_I;
      hold_sync_reg <= hold_meta_reg;
    end
  end

  // ----------------------------------------
  // Bus sequencer
  // ----------------------------------------
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      state_reg <= lbsi_pkg::MST_IDLE;
      REQ_READY_O <= 1'b0;
      BUS_GRANT_O <= 1'b0;
      write_reg <= 1'b0;
      size_reg <= '0;
      word_reg <= '0;
      wdata_reg <= '0;
      lad_reg <= '0;
      lad_oe_reg <= 1'b0;
      ale_n_reg <= 1'b1;
      ads_n_reg <= 1'b1;
      den_n_reg <= 1'b1;
      be_reg <= '0;
      RD_DATA_O <= '0;
      RD_VALID_O <= 1'b0;
      DONE_O <= 1'b0;
    end
    else
    begin
      RD_VALID_O <= 1'b0;
      DONE_O <= 1'b0;
      case (state_reg)
        lbsi_pkg::MST_IDLE:
        begin
          if (take)
          begin
            REQ_READY_O <= 1'b0;
            write_reg <= REQ_WRITE_I;
            size_reg <= REQ_SIZE_I;
            be_reg <= REQ_BE_I;
            wdata_reg <= REQ_WDATA_I;
            lad_reg <= {REQ_ADDR_I, REQ_SIZE_I};
            lad_oe_reg <= 1'b1;
            ale_n_reg <= 1'b0;
            ads_n_reg <= 1'b0;
            state_reg <= lbsi_pkg::MST_ADDR;
          end
          else if (hold_sync_reg)
          begin
            // Grant only from idle, so no transaction is ever cut short
            REQ_READY_O <= 1'b0;
            lad_oe_reg <= 1'b0;
            BUS_GRANT_O <= 1'b1;
            state_reg <= lbsi_pkg::MST_HOLD;
          end
          else
          begin
            REQ_READY_O <= 1'b1;
          end
        end
        lbsi_pkg::MST_ADDR:
        begin
          ale_n_reg <= 1'b1;
          ads_n_reg <= 1'b1;
          den_n_reg <= 1'b0;
          word_reg <= '0;
          lad_reg <= wdata_reg[lbsi_pkg::LAD_W-1:0];
          lad_oe_reg <= write_reg;
          state_reg <= lbsi_pkg::MST_DATA;
        end
        lbsi_pkg::MST_DATA:
        begin
          // Waits here for any number of cycles
          if (!BUS.ready_n)
          begin
            RD_DATA_O <= BUS.lad;
            RD_VALID_O <= !write_reg;
            if (word_reg == size_reg)
            begin
              DONE_O <= 1'b1;
              den_n_reg <= 1'b1;
              lad_oe_reg <= 1'b0;
              state_reg <= lbsi_pkg::MST_RECOV;
            end
            else
            begin
              word_reg <= word_reg + 1'b1;
              wdata_reg <= wdata_reg >> lbsi_pkg::LAD_W;
              lad_reg <= wdata_reg[2*lbsi_pkg::LAD_W-1:lbsi_pkg::LAD_W];
            end
          end
        end
        lbsi_pkg::MST_RECOV:
        begin
          state_reg <= lbsi_pkg::MST_IDLE;
        end
        lbsi_pkg::MST_HOLD:
        begin
          if (!hold_sync_reg)
          begin
            BUS_GRANT_O <= 1'b0;
            state_reg <= lbsi_pkg::MST_IDLE;
          end
        end
        default:
        begin
          state_reg <= lbsi_pkg::MST_IDLE;
        end
      endcase
    end
  end
endmodule : lbsi_proc_end

// >>> logic/lbsi_dev_end.sv
`timescale 1ns/1ps
module lbsi_fifo #(
  parameter int WIDTH = lbsi_pkg::PAY_W,
  parameter int DEPTH = lbsi_pkg::FIFO_DEPTH
) (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Async reset
  input wire logic in_valid_i, // Push request
  output logic in_ready_o, // Not full
  input wire logic [WIDTH-1:0] in_data_i, // Push data
  output logic out_valid_o, // Not empty
  input wire logic out_ready_i, // Pop request
  output logic [WIDTH-1:0] out_data_o, // Head word
  output logic [$clog2(DEPTH+1)-1:0] count_o // Fill level
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_C = PTR_W'(DEPTH - 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [CNT_W-1:0] count_reg;
  logic push;
  logic pop;

  assign in_ready_o = count_reg != DEPTH_C;
  assign out_valid_o = count_reg != '0;
  assign out_data_o = mem[rd_ptr_reg];
  assign count_o = count_reg;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= (wr_ptr_reg == LAST_C) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= (rd_ptr_reg == LAST_C) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop)
      begin
        count_reg <= count_reg + 1'b1;
      end
      else if (pop && !push)
      begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule : lbsi_fifo

module lbsi_dev_end #(
  parameter int DEPTH = lbsi_pkg::FIFO_DEPTH
) (
  input wire logic CLOCK_I, // System clock
  input wire logic SYS_RST_I, // Async reset, active high
  lbsi_bus_if.slave BUS, // Local bus pins
  output logic [lbsi_pkg::CS_W-1:0] CS_O, // One-hot chip select, held per transaction
  output logic IO_RD_N_O, // I/O read command, active low
  output logic IO_WR_N_O, // I/O write command, active low
  output logic BUS_EXT_OWNER_O, // External master owns bus
  output logic RD_REQ_O, // Read word wanted
  output logic [lbsi_pkg::WADDR_W-1:0] RD_ADDR_O, // Read word address
  output logic [lbsi_pkg::BE_W-1:0] RD_BE_O, // Read byte lanes
  input wire logic [lbsi_pkg::LAD_W-1:0] RD_DATA_I, // Read word from target
  input wire logic RD_VALID_I, // Read word present
  output logic RD_ACK_O, // Read word taken
  output logic NARROW_VALID_O, // Halfword write present
  input wire logic NARROW_READY_I, // Halfword write accepted
  output logic [lbsi_pkg::HALF_W-1:0] NARROW_DATA_O, // Halfword write data
  output logic [lbsi_pkg::WADDR_W:0] NARROW_ADDR_O, // Halfword address
  output logic [lbsi_pkg::HBE_W-1:0] NARROW_BE_O, // Halfword byte lanes
  output logic [lbsi_pkg::CS_W-1:0] NARROW_CS_O // Chip select of halfword
);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W:0] DEPTH_C = (CNT_W + 1)'(DEPTH);
  localparam int HI_LSB = lbsi_pkg::HALF_W;
  localparam int RGN_LSB = lbsi_pkg::ADDR_LSB + lbsi_pkg::CS_SEL_LSB;
  localparam logic [lbsi_pkg::CS_W-1:0] CS_ONE = lbsi_pkg::CS_W'(1);

  lbsi_pkg::lbsi_slv_state_type state_reg;
  logic [lbsi_pkg::WADDR_W-1:0] addr_reg;
  logic [lbsi_pkg::SIZE_W-1:0] left_reg;
  logic [lbsi_pkg::BE_W-1:0] be_reg;
  logic write_reg;
  logic ready_n_reg;
  logic [lbsi_pkg::LAD_W-1:0] s_lad_reg;
  logic s_lad_oe_reg;
  logic [lbsi_pkg::LAD_W-1:0] lane_mask;
  logic start;
  logic taken;
  logic last;
  logic push;
  logic room_after;
  logic [CNT_W-1:0] fifo_count;
  logic [CNT_W:0] fill_after;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [lbsi_pkg::PAY_W-1:0] fifo_out;
  logic [lbsi_pkg::PAY_W-1:0] nar_word_reg;
  logic nar_busy_reg;
  logic nar_high_pend_reg;

  assign BUS.s_lad = s_lad_reg;
  assign BUS.s_lad_oe = s_lad_oe_reg;
  assign BUS.ready_n = ready_n_reg;

  // ----------------------------------------
  // Cycle start and word handshake
  // ----------------------------------------
  // Same handling whoever drives the bus
  assign start = (state_reg == lbsi_pkg::SLV_IDLE) && !BUS.address_status_strobe_n && !BUS.ale_n;
  assign taken = (state_reg == lbsi_pkg::SLV_DATA) && !ready_n_reg;
  assign last = left_reg == lbsi_pkg::SIZE_ONE;
  assign push = taken && write_reg;
  // Pops are ignored here: ready is a cycle early, so only a sure slot may be promised
  assign fill_after = {1'b0, fifo_count} + {{CNT_W{1'b0}}, push};
  assign room_after = fill_after < DEPTH_C;

  for (genvar g = 0; g < lbsi_pkg::BE_W; g++)
  begin : g_lane
    assign lane_mask[g*lbsi_pkg::BYTE_W +: lbsi_pkg::BYTE_W] = {lbsi_pkg::BYTE_W{be_reg[g]}};
  end

  always_ff @(posedge CLOCK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      state_reg <= lbsi_pkg::SLV_IDLE;
      addr_reg <= '0;
      left_reg <= '0;
      be_reg <= '0;
      write_reg <= 1'b0;
      CS_O <= '0;
    end
    else if (start)
    begin
      addr_reg <= BUS.lad[lbsi_pkg::LAD_W-1:lbsi_pkg::ADDR_LSB];
      left_reg <= BUS.lad[lbsi_pkg::SIZE_W-1:0];
      be_reg <= BUS.be;
      write_reg <= BUS.w_r;
      CS_O <= CS_ONE << BUS.lad[RGN_LSB +: lbsi_pkg::CS_SEL_W];
      state_reg <= lbsi_pkg::SLV_DATA;
    end
    else if (taken)
    begin
      if (last)
      begin
        CS_O <= '0;
        state_reg <= lbsi_pkg::SLV_IDLE;
      end
      else
      begin
        addr_reg <= addr_reg + 1'b1;
        left_reg <= left_reg - 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Ready, read data and I/O commands
  // ----------------------------------------
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      ready_n_reg <= 1'b1;
      s_lad_reg <= '0;
      s_lad_oe_reg <= 1'b0;
      RD_ACK_O <= 1'b0;
    end
    else
    begin
      RD_ACK_O <= 1'b0;
      if (start)
      begin
        ready_n_reg <= !(BUS.w_r && room_after);
      end
      else if (taken)
      begin
        ready_n_reg <= !(write_reg && !last && room_after);
        s_lad_oe_reg <= s_lad_oe_reg && !last;
      end
      else if (state_reg == lbsi_pkg::SLV_DATA)
      begin
        if (write_reg)
        begin
          ready_n_reg <= !room_after;
        end
        else if (RD_VALID_I && !RD_ACK_O)
        begin
          // Drive only after the processor has turned its drivers off
          s_lad_reg <= RD_DATA_I & lane_mask;
          s_lad_oe_reg <= 1'b1;
          ready_n_reg <= 1'b0;
          RD_ACK_O <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge CLOCK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      IO_RD_N_O <= 1'b1;
      IO_WR_N_O <= 1'b1;
      RD_REQ_O <= 1'b0;
      RD_ADDR_O <= '0;
      RD_BE_O <= '0;
      BUS_EXT_OWNER_O <= 1'b0;
    end
    else
    begin
      BUS_EXT_OWNER_O <= BUS.bus_grant;
      if (start)
      begin
        IO_RD_N_O <= !(!BUS.w_r && BUS.lad[RGN_LSB +: lbsi_pkg::CS_SEL_W] == lbsi_pkg::IO_REGION);
        IO_WR_N_O <= !(BUS.w_r && BUS.lad[RGN_LSB +: lbsi_pkg::CS_SEL_W] == lbsi_pkg::IO_REGION);
        RD_REQ_O <= !BUS.w_r;
        RD_ADDR_O <= BUS.lad[lbsi_pkg::LAD_W-1:lbsi_pkg::ADDR_LSB];
        RD_BE_O <= BUS.be;
      end
      else if (taken)
      begin
        if (last)
        begin
          IO_RD_N_O <= 1'b1;
          IO_WR_N_O <= 1'b1;
          RD_REQ_O <= 1'b0;
        end
        else
        begin
          RD_ADDR_O <= addr_reg + 1'b1;
        end
      end
      else if (RD_ACK_O)
      begin
        RD_REQ_O <= 1'b0;
      end
      else if (state_reg == lbsi_pkg::SLV_DATA && !write_reg && ready_n_reg)
      begin
        RD_REQ_O <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Write buffer
  // ----------------------------------------
  lbsi_fifo #(
    .WIDTH(lbsi_pkg::PAY_W),
    .DEPTH(DEPTH)
  ) u_wr_fifo (
    .clk_i(CLOCK_I),
    .rst_i(SYS_RST_I),
    .in_valid_i(push),
    .in_ready_o(),
    .in_data_i({CS_O, addr_reg, be_reg, BUS.lad & lane_mask}),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(!nar_busy_reg),
    .out_data_o(fifo_out),
    .count_o(fifo_count)
  );

  assign fifo_pop = fifo_out_valid && !nar_busy_reg;

  // ----------------------------------------
  // Narrowing to halfword peripheral bus
  // ----------------------------------------
  // A stalled peripheral fills the buffer, which then withholds ready
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      nar_word_reg <= '0;
      nar_busy_reg <= 1'b0;
      nar_high_pend_reg <= 1'b0;
      NARROW_VALID_O <= 1'b0;
      NARROW_DATA_O <= '0;
      NARROW_ADDR_O <= '0;
      NARROW_BE_O <= '0;
      NARROW_CS_O <= '0;
    end
    else
    begin
      if (fifo_pop)
      begin
        nar_word_reg <= fifo_out;
        NARROW_CS_O <= fifo_out[lbsi_pkg::PAY_CS_LSB +: lbsi_pkg::CS_W];
        // Empty lane pairs are skipped; a word with no lanes emits nothing
        if (fifo_out[lbsi_pkg::PAY_BE_LSB +: lbsi_pkg::HBE_W] != '0)
        begin
          NARROW_DATA_O <= fifo_out[lbsi_pkg::PAY_DATA_LSB +: lbsi_pkg::HALF_W];
          NARROW_BE_O <= fifo_out[lbsi_pkg::PAY_BE_LSB +: lbsi_pkg::HBE_W];
          NARROW_ADDR_O <= {fifo_out[lbsi_pkg::PAY_ADDR_LSB +: lbsi_pkg::WADDR_W], 1'b0};
          NARROW_VALID_O <= 1'b1;
          nar_busy_reg <= 1'b1;
          nar_high_pend_reg <= fifo_out[lbsi_pkg::PAY_BE_LSB + lbsi_pkg::HBE_W +: lbsi_pkg::HBE_W] != '0;
        end
        else if (fifo_out[lbsi_pkg::PAY_BE_LSB + lbsi_pkg::HBE_W +: lbsi_pkg::HBE_W] != '0)
        begin
          NARROW_DATA_O <= fifo_out[lbsi_pkg::PAY_DATA_LSB + HI_LSB +: lbsi_pkg::HALF_W];
          NARROW_BE_O <= fifo_out[lbsi_pkg::PAY_BE_LSB + lbsi_pkg::HBE_W +: lbsi_pkg::HBE_W];
          NARROW_ADDR_O <= {fifo_out[lbsi_pkg::PAY_ADDR_LSB +: lbsi_pkg::WADDR_W], 1'b1};
          NARROW_VALID_O <= 1'b1;
          nar_busy_reg <= 1'b1;
          nar_high_pend_reg <= 1'b0;
        end
      end
      else if (NARROW_VALID_O && NARROW_READY_I)
      begin
        if (nar_high_pend_reg)
        begin
          NARROW_DATA_O <= nar_word_reg[lbsi_pkg::PAY_DATA_LSB + HI_LSB +: lbsi_pkg::HALF_W];
          NARROW_BE_O <= nar_word_reg[lbsi_pkg::PAY_BE_LSB + lbsi_pkg::HBE_W +: lbsi_pkg::HBE_W];
          NARROW_ADDR_O <= {nar_word_reg[lbsi_pkg::PAY_ADDR_LSB +: lbsi_pkg::WADDR_W], 1'b1};
          nar_high_pend_reg <= 1'b0;
        end
        else
        begin
          NARROW_VALID_O <= 1'b0;
          nar_busy_reg <= 1'b0;
        end
      end
    end
  end
endmodule : lbsi_dev_end

// >>> verification/lbsi_bus_assertions.sv
`timescale 1ns/1ps
module lbsi_bus_assertions (
  input wire logic CLOCK_I, // Clock
  input wire logic SYS_RST_I, // Reset
  input wire logic m_lad_oe, // Proc drives
  input wire logic s_lad_oe, // Dev drives
  input wire logic [lbsi_pkg::LAD_W-1:0] lad, // Shared wire
  input wire logic ale_n, // Latch
  input wire logic address_status_strobe_n, // Status
  input wire logic w_r, // Write
  input wire logic data_direction, // Direction
  input wire logic data_transceiver_enable_n, // Data phase
  input wire logic [lbsi_pkg::BE_W-1:0] be, // Lanes
  input wire logic ready_n, // Ready
  input wire logic bus_grant // Grant
);
  // ----------------------------------------
  // Words left in the transaction after the current one
  // ----------------------------------------
  logic [1:0] left_reg;
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
      left_reg <= 2'h0;
    else if (!address_status_strobe_n)
      left_reg <= lad[1:0];
    else if (!ready_n && !data_transceiver_enable_n)
      left_reg <= left_reg - 2'h1;
  end
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I);
  sequence s_addr_state;
    !address_status_strobe_n && !ale_n;
  endsequence
  a_latch_with_status: assert property (ale_n == address_status_strobe_n)
    else $error("latch strobe differs from status strobe");
  a_status_one_cycle: assert property (!address_status_strobe_n |=> address_status_strobe_n)
    else $error("status strobe longer than one cycle");
  a_data_follows: assert property (s_addr_state |=> !data_transceiver_enable_n)
    else $error("no data phase after address state");
  a_dir_steady: assert property (!data_transceiver_enable_n && !$past(data_transceiver_enable_n) |-> $stable(data_direction))
    else $error("direction changed in data phase");
  a_dir_matches: assert property (!data_transceiver_enable_n |-> data_direction == w_r)
    else $error("direction differs from write line");
  a_lanes_held: assert property (!data_transceiver_enable_n |-> $stable(be))
    else $error("lanes changed in transaction");
  a_ready_in_data: assert property (!ready_n |-> !data_transceiver_enable_n)
    else $error("ready outside data phase");
  a_read_word_pulse: assert property (!ready_n && !w_r |-> s_lad_oe && !m_lad_oe ##1 ready_n)
    else $error("read word not driven for one cycle");
  a_burst_count: assert property (!ready_n |=> data_transceiver_enable_n == ($past(left_reg) == 2'h0))
    else $error("data phase length differs from size code");
  a_grant_quiet: assert property (bus_grant |-> data_transceiver_enable_n && !m_lad_oe)
    else $error("bus driven while granted away");
endmodule : lbsi_bus_assertions

// >>> verification/test_local_bus_slave_interface.sv
`timescale 1ns/1ps
module test_local_bus_slave_interface;
  // ----------------------------------------
  // Stimulus and observation
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [29:0] req_addr = 30'h0;
  logic [1:0] req_size = 2'h0;
  logic [3:0] req_be = 4'h0;
  logic [127:0] req_wdata = 128'h0;
  logic hold = 1'b0;
  logic rd_ok = 1'b1;
  logic nready = 1'b1;
  logic req_ready, grant, rd_valid, done, io_rd_n, io_wr_n, ext_owner, rd_req, rd_ack, n_valid;
  logic saw_iow, saw_ior;
  logic [31:0] rd_data, dev_rd_data;
  logic [29:0] rd_addr;
  logic [3:0] rd_be, cs, n_cs, last_cs;
  logic [15:0] n_data;
  logic [30:0] n_addr;
  logic [1:0] n_be;
  logic [52:0] exp_q[$];
  logic [3:0] be_tab [4] = '{4'h3, 4'hC, 4'hF, 4'hF};
  int bad_count = 0;
  int n_compared = 0;
  int lat;
  int i;
  initial
  begin
    forever #5 clk = ~clk;
  end
  assign dev_rd_data = {rd_addr, 2'h2};
  lbsi_bus_if u_lbsi_bus_if ();
  lbsi_proc_end u_lbsi_proc_end (.CLOCK_I(clk), .SYS_RST_I(rst), .BUS(u_lbsi_bus_if), .REQ_VALID_I(req_valid),
    .REQ_READY_O(req_ready), .REQ_WRITE_I(req_write), .REQ_ADDR_I(req_addr), .REQ_SIZE_I(req_size),
    .REQ_BE_I(req_be), .REQ_WDATA_I(req_wdata), .HOLD_I(hold), .BUS_GRANT_O(grant), .RD_DATA_O(rd_data),
    .RD_VALID_O(rd_valid), .DONE_O(done));
  lbsi_dev_end #(.DEPTH(32)) u_lbsi_dev_end (.CLOCK_I(clk), .SYS_RST_I(rst), .BUS(u_lbsi_bus_if), .CS_O(cs),
    .IO_RD_N_O(io_rd_n), .IO_WR_N_O(io_wr_n), .BUS_EXT_OWNER_O(ext_owner), .RD_REQ_O(rd_req),
    .RD_ADDR_O(rd_addr), .RD_BE_O(rd_be), .RD_DATA_I(dev_rd_data), .RD_VALID_I(rd_ok), .RD_ACK_O(rd_ack),
    .NARROW_VALID_O(n_valid), .NARROW_READY_I(nready), .NARROW_DATA_O(n_data), .NARROW_ADDR_O(n_addr),
    .NARROW_BE_O(n_be), .NARROW_CS_O(n_cs));
  lbsi_bus_assertions u_lbsi_bus_assertions (.CLOCK_I(clk), .SYS_RST_I(rst), .m_lad_oe(u_lbsi_bus_if.m_lad_oe),
    .s_lad_oe(u_lbsi_bus_if.s_lad_oe), .lad(u_lbsi_bus_if.lad), .ale_n(u_lbsi_bus_if.ale_n),
    .address_status_strobe_n(u_lbsi_bus_if.address_status_strobe_n), .w_r(u_lbsi_bus_if.w_r),
    .data_direction(u_lbsi_bus_if.data_direction), .be(u_lbsi_bus_if.be), .ready_n(u_lbsi_bus_if.ready_n),
    .data_transceiver_enable_n(u_lbsi_bus_if.data_transceiver_enable_n), .bus_grant(u_lbsi_bus_if.bus_grant));
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("Compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  // Far side takes halves only while ready is up
  always @(posedge clk)
  begin
    if (!rst && n_valid && nready)
    begin
      if (exp_q.size() == 0)
        check("narrow extra", 1, 0);
      else
        check("narrow half", {n_cs, n_addr, n_be, n_data}, exp_q.pop_front());
    end
    if (!io_wr_n)
      saw_iow <= 1'b1;
    if (!io_rd_n)
      saw_ior <= 1'b1;
    if (!u_lbsi_bus_if.ready_n)
      last_cs <= cs;
    if (!rst && rd_ack)
      check("read ack", {rd_req, u_lbsi_bus_if.ready_n}, 2'h2);
  end
  task automatic xfer(input logic wr, input logic [29:0] a, input logic [1:0] sz, input logic [3:0] b);
    logic [31:0] w;
    int words;
    words = 0;
    lat = 0;
    @(negedge clk);
    {req_valid, req_write, req_addr, req_size, req_be} = {1'b1, wr, a, sz, b};
    for (int n = 0; n < 4; n++)
    begin
      w = {a + 30'(n), 2'h1} ^ 32'h5A5A0F0F;
      req_wdata[32*n+:32] = w;
      if (wr && n <= sz && b[1:0] != 2'h0)
        exp_q.push_back({4'h1 << a[29:28], a + 30'(n), 1'b0, b[1:0], w[15:0]});
      if (wr && n <= sz && b[3:2] != 2'h0)
        exp_q.push_back({4'h1 << a[29:28], a + 30'(n), 1'b1, b[3:2], w[31:16]});
    end
    while (!req_ready && lat < 500)
    begin
      @(negedge clk);
      lat++;
    end
    @(negedge clk);
    req_valid = 1'b0;
    lat = 0;
    while (!done && lat < 500)
    begin
      @(negedge clk);
      lat++;
      if (rd_valid)
      begin
        check("read word", rd_data, {a + 30'(words), 2'h2} & {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}});
        check("read lanes", rd_be, b);
        words++;
      end
    end
    check("read words", words, wr ? 0 : sz + 1);
  endtask : xfer
  initial
  begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    for (int s = 0; s < 4; s++)
    begin
      for (int w = 1; w >= 0; w--)
      begin
        saw_iow = 1'b0;
        saw_ior = 1'b0;
        xfer(w[0], {s[1:0], 28'h0000100}, s[1:0], be_tab[s]);
        check("io write strobe", saw_iow, s == 3 && w == 1);
        check("io read strobe", saw_ior, s == 3 && w == 0);
        check("chip select", last_cs, 4'h1 << s);
      end
    end
    rd_ok = 1'b0;
    fork
      begin
        repeat (12) @(negedge clk);
        rd_ok = 1'b1;
      end
      xfer(1'b0, 30'h01000200, 2'h1, 4'hF);
    join
    check("stalled read", lat > 12, 1);
    nready = 1'b0;
    for (i = 0; i < 8; i++)
      xfer(1'b1, 30'h00001000 + 30'(4 * i), 2'h3, 4'hF);
    fork
      begin
        repeat (30) @(negedge clk);
        nready = 1'b1;
      end
      xfer(1'b1, 30'h00002000, 2'h1, 4'hF);
    join
    check("full buffer stalls", lat > 30, 1);
    for (i = 0; i < 300 && exp_q.size() != 0; i++)
      @(negedge clk);
    check("buffer drained", exp_q.size(), 0);
    hold = 1'b1;
    for (i = 0; i < 20 && !grant; i++)
      @(negedge clk);
    @(negedge clk);
    check("grant given", {grant, ext_owner, req_ready}, 3'h6);
    hold = 1'b0;
    repeat (6) @(negedge clk);
    check("grant released", grant, 0);
    xfer(1'b0, 30'h02000000, 2'h0, 4'hF);
    conclude();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    conclude();
  end
endmodule : test_local_bus_slave_interface
